// ### hdl/dgp_top.sv
// two general-purpose pins: configuration word, output drive and PWM input decode
`timescale 1ns/10ps
`include "dgp_map.svh"

module dgp_top
   import dgp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic cfg_wr,
   input wire logic [11:0] cfg_wdata,
   output logic [11:0] cfg_rdata,
   input wire logic gp_pin_zero_in,
   output logic gp_pin_zero_out,
   output logic gp_pin_zero_oe,
   input wire logic gp_pin_one_in,
   output logic gp_pin_one_out,
   output logic gp_pin_one_oe,
   output logic [1:0] pin_level
);

   dgp_state_s state_reg;
   dgp_state_s state_next;

   // decoded configuration fields
   logic pin_zero_direction;
   logic pin_one_direction;
   logic pin_zero_output_level;
   logic pin_one_output_level;
   logic pin_zero_input_format;
   logic pin_one_input_format;
   dgp_tb_t pin_zero_pwm_timebase;
   dgp_tb_t pin_one_pwm_timebase;
   logic [1:0] spare_bits;

   // per-pin views for the loop
   logic [1:0] dir_vec;
   logic [1:0] fmt_vec;
   logic [1:0] raw_in;
   dgp_tb_t [1:0] tb_vec;
   dgp_pin_s [1:0] pins;

   // field extraction from the stored configuration word
   assign pin_zero_output_level = state_reg.cfg[`DGP_BIT_DAT0];
   assign pin_one_output_level = state_reg.cfg[`DGP_BIT_DAT1];
   assign spare_bits = state_reg.cfg[`DGP_LSB_SPARE +: 2];
   assign pin_zero_pwm_timebase = state_reg.cfg[`DGP_LSB_TB0 +: 2];
   assign pin_one_pwm_timebase = state_reg.cfg[`DGP_LSB_TB1 +: 2];
   assign pin_zero_direction = state_reg.cfg[`DGP_BIT_DIR0];
   assign pin_one_direction = state_reg.cfg[`DGP_BIT_DIR1];
   assign pin_zero_input_format = state_reg.cfg[`DGP_BIT_FMT0];
   assign pin_one_input_format = state_reg.cfg[`DGP_BIT_FMT1];

   // gather per-pin controls so both pins share one body of logic
   assign dir_vec = {pin_one_direction, pin_zero_direction};
   assign fmt_vec = {pin_one_input_format, pin_zero_input_format};
   assign tb_vec[0] = pin_zero_pwm_timebase;
   assign tb_vec[1] = pin_one_pwm_timebase;
   assign raw_in = {gp_pin_one_in, gp_pin_zero_in};

   // time base select to tick length; 1024 does not fit ten bits,
   // so the prescaler compares against length minus one
   function automatic logic [9:0] tb_last(input dgp_tb_t sel);
      logic [9:0] len;
      len = `DGP_TB_SEL0;
      unique case (sel)
         2'b00: len = `DGP_TB_SEL0 - 10'd1;
         2'b01: len = `DGP_TB_SEL1 - 10'd1;
         2'b10: len = `DGP_TB_SEL2 - 10'd1;
         2'b11: len = 10'h3ff;
      endcase
      return len;
   endfunction

   // pin drive: outputs only ever carry static levels, never PWM
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
         logic dat;
         assign dat = state_reg.cfg[gi];
         assign pins[gi].pin_in = raw_in[gi];
         // enable follows the direction bit
         assign pins[gi].pin_oe = dir_vec[gi];
         // level bit gated by direction so an input pin never sees it
         assign pins[gi].pin_out = dir_vec[gi] & dat;
      end
   endgenerate

   assign gp_pin_zero_out = pins[0].pin_out;
   assign gp_pin_zero_oe = pins[0].pin_oe;
   assign gp_pin_one_out = pins[1].pin_out;
   assign gp_pin_one_oe = pins[1].pin_oe;

   // readback of the whole word, spare bits included
   assign cfg_rdata = state_reg.cfg;
   assign pin_level = state_reg.level;

   // next-state logic for the configuration word and both input paths
   always_comb begin
      logic s;
      logic rise;
      logic tick;
      s = 1'b0;
      rise = 1'b0;
      tick = 1'b0;
      state_next = state_reg;

      // software write replaces the whole word, spare bits too
      if (cfg_wr) begin
         state_next.cfg = cfg_wdata;
      end

      for (int i = 0; i < 2; i++) begin
         // two-stage synchroniser; only the second stage is read below
         state_next.chan[i].sync1 = pins[i].pin_in;
         state_next.chan[i].sync2 = state_reg.chan[i].sync1;
         s = state_reg.chan[i].sync2;
         state_next.chan[i].prev = s;
         rise = s & ~state_reg.chan[i].prev;

         // prescaler produces one tick per selected time base
         tick = (state_reg.chan[i].prescale >= tb_last(tb_vec[i]));
         if (tick) begin
            state_next.chan[i].prescale = 10'h000;
         end else begin
            state_next.chan[i].prescale = state_reg.chan[i].prescale + 10'h001;
         end

         // count high and low ticks, saturating to bound the counters
         if (tick) begin
            if (s) begin
               if (state_reg.chan[i].hi_cnt != `DGP_CNT_MAX) begin
                  state_next.chan[i].hi_cnt = state_reg.chan[i].hi_cnt + 8'h01;
               end
            end else begin
               if (state_reg.chan[i].lo_cnt != `DGP_CNT_MAX) begin
                  state_next.chan[i].lo_cnt = state_reg.chan[i].lo_cnt + 8'h01;
               end
            end
         end

         // each rising edge closes a period; duty above half reads as high
         if (rise) begin
            state_next.chan[i].pwm_level =
               (state_reg.chan[i].hi_cnt > state_reg.chan[i].lo_cnt);
            state_next.chan[i].hi_cnt = 8'h00;
            state_next.chan[i].lo_cnt = 8'h00;
         end else if (state_reg.chan[i].hi_cnt == `DGP_CNT_MAX) begin
            // stuck high for a long time counts as full duty
            state_next.chan[i].pwm_level = 1'b1;
         end else if (state_reg.chan[i].lo_cnt == `DGP_CNT_MAX) begin
            // stuck low means zero duty
            state_next.chan[i].pwm_level = 1'b0;
         end

         // reported level: static sample or decoded duty per format bit
         if (fmt_vec[i]) begin
            state_next.level[i] = state_reg.chan[i].pwm_level;
         end else begin
            state_next.level[i] = s;
         end

         // an output pin reads back its own static drive level
         if (dir_vec[i]) begin
            state_next.level[i] = pins[i].pin_out;
         end
      end
   end

   // single state register; every field clears on reset
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= '0;
         state_reg.cfg <= `DGP_CFG_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule

// ### inc/dgp_map.svh
// constants for the dual general-purpose pin configuration block
`ifndef DGP_MAP_SVH
`define DGP_MAP_SVH

// configuration word layout
`define DGP_CFG_WIDTH 12
`define DGP_CFG_RESET 12'h000
`define DGP_BIT_DAT0 0
`define DGP_BIT_DAT1 1
`define DGP_LSB_SPARE 2
`define DGP_LSB_TB0 4
`define DGP_LSB_TB1 6
`define DGP_BIT_DIR0 8
`define DGP_BIT_DIR1 9
`define DGP_BIT_FMT0 10
`define DGP_BIT_FMT1 11

// time base lengths in master clock periods
`define DGP_TB_SEL0 10'd16
`define DGP_TB_SEL1 10'd64
`define DGP_TB_SEL2 10'd256
`define DGP_TB_SEL3 11'd1024

// duty counter saturation in ticks
`define DGP_CNT_MAX 8'hff

`endif

// ### inc/dgp_pkg.sv
// types for the dual general-purpose pin configuration block
package dgp_pkg;

   typedef logic [1:0] dgp_tb_t;

   // per-pin input path and duty measurement state
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic [9:0] prescale;
      logic [7:0] hi_cnt;
      logic [7:0] lo_cnt;
      logic pwm_level;
   } dgp_chan_s;

   // pin-side signals of one pin
   typedef struct packed {
      logic pin_in;
      logic pin_out;
      logic pin_oe;
   } dgp_pin_s;

   // whole module state
   typedef struct packed {
      logic [11:0] cfg;
      dgp_chan_s [1:0] chan;
      logic [1:0] level;
   } dgp_state_s;

endpackage

// ### tb/dgp_pins_model.sv
// outside source and load on one general-purpose pin
`timescale 1ns/10ps
module dgp_pins_model (
   input wire logic clk,
   input wire logic pwm_on,
   input wire logic static_lvl,
   input wire logic [15:0] hi_cycles,
   input wire logic [15:0] lo_cycles,
   input wire logic pin_oe,
   input wire logic pin_out,
   output logic pin_in
);
   logic [15:0] cnt = 16'h0000;
   logic src;
   // pwm phase restarts when pwm is off, so each run starts with a rising edge
   always @(posedge clk) begin
      cnt <= (!pwm_on || cnt >= hi_cycles + lo_cycles - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
   end
   assign src = pwm_on ? (cnt < hi_cycles) : static_lvl;
   // the block owns the wire while it drives, else the source does
   assign pin_in = pin_oe ? pin_out : src;
endmodule

// ### tb/dgp_top_asserts.sv
// checker for the dual general-purpose pin block
`timescale 1ns/10ps
module dgp_top_asserts import dgp_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic cfg_wr,
   input wire logic [11:0] cfg_wdata,
   input wire logic [11:0] cfg_rdata,
   input wire logic gp_pin_zero_in,
   input wire logic gp_pin_zero_out,
   input wire logic gp_pin_zero_oe,
   input wire logic gp_pin_one_out,
   input wire logic gp_pin_one_oe,
   input wire logic [1:0] pin_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // four quiet config samples cover the whole two-flop sync path
   sequence s_static0;
      (!cfg_rdata[10] && !cfg_rdata[8]) [*4];
   endsequence
   sequence s_drive0;
      cfg_rdata[8] [*2];
   endsequence
   a_dir_zero: assert property (cfg_wr |=> gp_pin_zero_oe == $past(cfg_wdata[8]))
      else $error("pin zero enable wrong after write");
   a_dir_one: assert property (cfg_wr |=> gp_pin_one_oe == $past(cfg_wdata[9]))
      else $error("pin one enable wrong after write");
   a_out_zero: assert property (cfg_wr |=> gp_pin_zero_out == $past(cfg_wdata[8] & cfg_wdata[0]))
      else $error("pin zero drive wrong after write");
   a_out_one: assert property (cfg_wr |=> gp_pin_one_out == $past(cfg_wdata[9] & cfg_wdata[1]))
      else $error("pin one drive wrong after write");
   a_word_store: assert property (cfg_wr |=> cfg_rdata == $past(cfg_wdata))
      else $error("written word not read back");
   a_word_hold: assert property (!cfg_wr |=> $stable(cfg_rdata))
      else $error("config changed without write");
   a_static_in: assert property (s_static0 |-> pin_level[0] == $past(gp_pin_zero_in, 3))
      else $error("static input level not followed");
   a_own_level: assert property (s_drive0 |-> pin_level[0] == $past(gp_pin_zero_out))
      else $error("output pin does not see its own drive");
endmodule
bind dgp_top dgp_top_asserts u_chk (.clk(clk), .reset(reset), .cfg_wr(cfg_wr),
   .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .gp_pin_zero_in(gp_pin_zero_in),
   .gp_pin_zero_out(gp_pin_zero_out), .gp_pin_zero_oe(gp_pin_zero_oe),
   .gp_pin_one_out(gp_pin_one_out), .gp_pin_one_oe(gp_pin_one_oe), .pin_level(pin_level));

// ### tb/dgp_top_test.sv
// self-checking bench for the dual general-purpose pin block
`timescale 1ns/10ps
`define check(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module dgp_top_test import dgp_pkg::*;;
   typedef struct packed {logic [11:0] w; logic [3:0] e;} dgp_row_s;
   // expected drive as {one oe, one out, zero oe, zero out}
   dgp_row_s rows [7] = '{'{12'h101, 4'h3}, '{12'h001, 4'h0}, '{12'h100, 4'h2},
      '{12'h202, 4'hc}, '{12'h002, 4'h0}, '{12'h00c, 4'h0}, '{12'h3ff, 4'hf}};
   logic clk = 1'b0, reset = 1'b1, cfg_wr = 1'b0, pwm = 1'b0;
   logic [11:0] cfg_wdata = 12'h000;
   logic [11:0] cfg_rdata;
   logic [1:0] lvl = 2'h0;
   logic [1:0] pin_level;
   logic [15:0] hi = 16'h0001, lo = 16'h0001;
   logic z_in, z_out, z_oe, o_in, o_out, o_oe;
   int n_tests = 0, miscompares = 0;
   dgp_top uut (.clk(clk), .reset(reset), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .gp_pin_zero_in(z_in), .gp_pin_zero_out(z_out),
      .gp_pin_zero_oe(z_oe), .gp_pin_one_in(o_in), .gp_pin_one_out(o_out),
      .gp_pin_one_oe(o_oe), .pin_level(pin_level));
   dgp_pins_model m0 (.clk(clk), .pwm_on(pwm), .static_lvl(lvl[0]), .hi_cycles(hi),
      .lo_cycles(lo), .pin_oe(z_oe), .pin_out(z_out), .pin_in(z_in));
   dgp_pins_model m1 (.clk(clk), .pwm_on(pwm), .static_lvl(lvl[1]), .hi_cycles(hi),
      .lo_cycles(lo), .pin_oe(o_oe), .pin_out(o_out), .pin_in(o_in));
   initial forever #10 clk = ~clk;
   task automatic wr(input logic [11:0] w);
      cfg_wdata = w;
      cfg_wr = 1'b1;
      @(posedge clk);
      #1 cfg_wr = 1'b0;
      // one idle edge so a following write never lowers and raises the strobe in one step
      @(posedge clk);
      #1;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // pwm runs: sample in the minority phase, where a static read would differ
   task automatic pwm_run(input logic [15:0] h, input logic [15:0] l, input int w);
      hi = h;
      lo = l;
      pwm = 1'b1;
      repeat (w) @(posedge clk);
      #1 pwm = 1'b0;
      // let the source idle one edge so its phase counter restarts before the next run
      @(posedge clk);
      #1;
   endtask
   // the limit allows about twice the expected run
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      `check({cfg_rdata, z_oe, o_oe, pin_level}, 16'h0000)
      foreach (rows[i]) begin
         wr(rows[i].w);
         `check(cfg_rdata, rows[i].w)
         `check({o_oe, o_out, z_oe, z_out}, rows[i].e)
      end
      repeat (2) @(posedge clk);
      #1;
      `check(pin_level, 2'h3)
      wr(12'h000);
      lvl = 2'h1;
      repeat (4) @(posedge clk);
      #1;
      `check(pin_level, 2'h1)
      lvl = 2'h0;
      // pin zero on 16-clock base, pin one on 256-clock base
      wr(12'hc80);
      pwm_run(16'd2560, 16'd512, 11876);
      `check(pin_level, 2'h3)
      pwm_run(16'd512, 16'd2560, 9316);
      `check(pin_level, 2'h0)
      wr(12'h3ff);
      reset = 1'b1;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      `check({cfg_rdata, z_oe, o_oe, z_out, o_out}, 16'h0000)
      give_verdict();
   end
endmodule
